// ==== psfs_pkg.sv ====
// Purpose: Shared constants and types for the power switch fault supervisor
// Assumes: 50 MHz ref_clk, all pin-level inputs already synchronous
// Notes: Register map is reached over AHB-Lite
package psfs_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DRIVE = 8'h08;
  localparam int CLK_MHZ = 50;
  localparam int SC_RESET_US = 100;
  localparam int SC_RESET_CYC = SC_RESET_US * CLK_MHZ;
  localparam int SLOW_OFF_NS = 200;
  localparam int SLOW_OFF_CYC = (SLOW_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_NS = 1000;
  localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_CYC = 1024;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [1:0] SLEW_EXT = 2'h0;
  localparam logic [1:0] SLEW_150 = 2'h1;
  localparam logic [1:0] SLEW_100 = 2'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {
    ST_START, ST_RUN, ST_CYCLE_OFF, ST_SHORT_OFF, ST_DIODE_EMU, ST_DRV_HOT, ST_SUPPLY_UNDERVOLTAGE_LOCK
  } psfs_state_e;
endpackage : psfs_pkg

// ==== psfs_top.sv ====
// Purpose: Protection and fault reporting logic of a power switch with gate driver
// Assumes: Comparator and pin inputs synchronous to ref_clk; AHB-Lite single word transfers
// Notes: Outputs are all registered; software may read status and set a combined-report mode
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module psfs_top #(
  parameter int SC_RESET_CYCLES = psfs_pkg::SC_RESET_CYC // Latch reset hold time
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic switch_cmd, // Switch command from controller
  input wire logic over_current, // Drain current above cycle limit
  input wire logic short_current, // Drain current above short limit
  input wire logic reverse_current, // Third-quadrant current sensed
  input wire logic die_hot, // Die sensor above trip (hysteretic)
  input wire logic driver_hot, // Driver sensor above trip (hysteretic)
  input wire logic supply_low, // Supply below lockout threshold
  input wire logic bias_below_9v, // Bias under 9 V
  input wire logic series_fet_on, // Series transistor is on
  input wire logic drv_pin_open, // Drive pin seen open
  input wire logic drv_pin_gnd, // Drive pin shorted to ground
  input wire logic drv_pin_rail, // Drive pin shorted to 5 V rail
  input wire logic current_fault_in, // Level on current fault pin
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic gate_on, // Switch gate command
  output logic slow_turnoff, // Slowed turn-off drive
  output logic aux_5v_regulator_en, // Aux regulator enable
  output logic negative_gate_rail_en, // Negative rail converter enable
  output logic [1:0] slew_sel, // Turn-on slew selection
  output logic freq_limit, // Reduced max switching frequency
  output logic temp_force_high, // Force temperature output high
  output logic general_fault_n, // General fault, active low
  output logic current_fault_n, // Current fault, active low
  output logic current_fault_oe // Current fault pin drive enable
);
  typedef struct packed {
    psfs_pkg::psfs_state_e st;
    logic [15:0] cnt;
    logic [15:0] filt;
    logic [1:0] slew;
    logic rail_locked;
    logic checked;
    logic merged;
    logic merge_sw;
    logic sc_held;
    logic [15:0] slow_cnt;
    logic rdy;
    logic resp;
    logic ap_wr;
    logic ap_act;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic gate;
    logic slow;
    logic aux_en;
    logic neg_en;
    logic flim;
    logic thot;
    logic gf_n;
    logic cf_n;
    logic cf_oe;
  } psfs_state_s;

  psfs_state_s s_q, s_d;

  // Status word shows state, flags and slew
  function automatic logic [31:0] status_word(input psfs_state_s s);
    status_word = {21'h000000, s.merged, s.rail_locked, s.slew, s.cf_n, s.gf_n, s.gate,
                   1'b0, s.st};
  endfunction : status_word

  // Main next-state logic; protection acts regardless of pin readback
  always_comb begin
    s_d = s_q;
    s_d.slow = 1'b0;
    s_d.flim = bias_below_9v;
    s_d.thot = die_hot | driver_hot;
    // Fault state machine, priority from most severe down
    unique case (s_q.st)
      psfs_pkg::ST_START: begin
        if (series_fet_on && !supply_low) begin
          s_d.st = psfs_pkg::ST_RUN;
        end
      end
      default: begin
        if (supply_low) begin
          s_d.st = psfs_pkg::ST_SUPPLY_UNDERVOLTAGE_LOCK;
        end else if (driver_hot) begin
          s_d.st = psfs_pkg::ST_DRV_HOT;
        end else if (s_q.sc_held) begin
          // Long command low releases the latch; a latch that outlived a
          // driver overheat picks up here instead of falling back to run
          s_d.st = psfs_pkg::ST_SHORT_OFF;
          if (switch_cmd) begin
            s_d.cnt = psfs_pkg::CNT_ZERO;
          end else if (s_q.cnt >= 16'(SC_RESET_CYCLES - 1)) begin
            s_d.st = psfs_pkg::ST_RUN;
            s_d.cnt = psfs_pkg::CNT_ZERO;
          end else begin
            s_d.cnt = s_q.cnt + psfs_pkg::CNT_ONE;
          end
        end else if (short_current) begin
          s_d.st = psfs_pkg::ST_SHORT_OFF;
          s_d.cnt = psfs_pkg::CNT_ZERO;
        end else if (die_hot) begin
          s_d.st = psfs_pkg::ST_DIODE_EMU;
        end else if (s_q.st == psfs_pkg::ST_CYCLE_OFF) begin
          if (!switch_cmd) begin
            s_d.st = psfs_pkg::ST_RUN;
          end
        end else if (over_current && switch_cmd) begin
          s_d.st = psfs_pkg::ST_CYCLE_OFF;
        end else begin
          s_d.st = psfs_pkg::ST_RUN;
        end
      end
    endcase
    if (s_d.st == psfs_pkg::ST_SHORT_OFF && s_q.st != psfs_pkg::ST_SHORT_OFF) begin
      s_d.cnt = psfs_pkg::CNT_ZERO;
    end
    // The latch outlives a driver overheat; only undervoltage or release clears it
    s_d.sc_held = (s_d.st == psfs_pkg::ST_SHORT_OFF)
                  || (s_q.sc_held && s_d.st == psfs_pkg::ST_DRV_HOT);
    // Slow turn-off drive for a fixed time after a fresh short; re-entry after a
    // driver overheat does not restart it, the switch is already off by then
    if (s_d.st == psfs_pkg::ST_SHORT_OFF && !s_q.sc_held) begin
      s_d.slow_cnt = 16'(psfs_pkg::SLOW_OFF_CYC);
    end else if (s_q.slow_cnt != psfs_pkg::CNT_ZERO) begin
      s_d.slow_cnt = s_q.slow_cnt - psfs_pkg::CNT_ONE;
    end
    s_d.slow = (s_d.slow_cnt != psfs_pkg::CNT_ZERO)
               && (s_d.st == psfs_pkg::ST_SHORT_OFF);
    // Gate and rail drive per next state; no fault pin readback enters here
    s_d.aux_en = (s_d.st != psfs_pkg::ST_DRV_HOT);
    s_d.neg_en = (s_d.st != psfs_pkg::ST_DRV_HOT);
    unique case (s_d.st)
      psfs_pkg::ST_RUN: s_d.gate = switch_cmd;
      psfs_pkg::ST_DIODE_EMU: s_d.gate = reverse_current;
      default: s_d.gate = 1'b0;
    endcase
    // Combined-report strap caught once on the first clock of start-up, not under reset
    if (s_q.st == psfs_pkg::ST_START && !s_q.merge_sw) begin
      s_d.merge_sw = 1'b1;
      s_d.merged = !current_fault_in;
    end
    // Drive pin: rail short checked once, else slow filter on changes
    if (!s_q.checked) begin
      s_d.checked = 1'b1;
      s_d.rail_locked = drv_pin_rail;
      s_d.slew = drv_pin_rail ? psfs_pkg::SLEW_100 : (drv_pin_gnd ? psfs_pkg::SLEW_150
                                                     : psfs_pkg::SLEW_EXT);
    end else if (!s_q.rail_locked) begin
      if ((drv_pin_gnd ? psfs_pkg::SLEW_150 : psfs_pkg::SLEW_EXT) == s_q.slew) begin
        s_d.filt = psfs_pkg::CNT_ZERO;
      end else if (s_q.filt >= 16'(psfs_pkg::FILT_CYC - 1)) begin
        s_d.slew = drv_pin_gnd ? psfs_pkg::SLEW_150 : psfs_pkg::SLEW_EXT;
        s_d.filt = psfs_pkg::CNT_ZERO;
      end else begin
        s_d.filt = s_q.filt + psfs_pkg::CNT_ONE;
      end
    end
    // Fault pin encoding; short outranks overcurrent
    unique case (s_d.st)
      psfs_pkg::ST_SHORT_OFF: begin
        s_d.gf_n = 1'b0;
        s_d.cf_n = 1'b0;
      end
      psfs_pkg::ST_CYCLE_OFF: begin
        s_d.gf_n = s_q.merged ? 1'b0 : 1'b1;
        s_d.cf_n = 1'b0;
      end
      psfs_pkg::ST_RUN: begin
        s_d.gf_n = !drv_pin_open;
        s_d.cf_n = 1'b1;
      end
      default: begin
        s_d.gf_n = 1'b0;
        s_d.cf_n = 1'b1;
      end
    endcase
    s_d.cf_oe = !s_d.merged;
    // AHB-Lite slave: zero-wait, address phase captured when ready
    s_d.rdy = 1'b1; // Zero wait states, so the bus never stalls
    s_d.resp = 1'b0;
    if (hready) begin
      s_d.ap_act = hsel && (htrans == psfs_pkg::HTRANS_NONSEQ);
      s_d.ap_wr = hwrite;
      s_d.ap_addr = haddr[7:0];
    end
    s_d.rdata = 32'h00000000;
    if (hready && hsel && htrans == psfs_pkg::HTRANS_NONSEQ && !hwrite) begin
      unique case (haddr[7:0])
        psfs_pkg::ADDR_CTRL: s_d.rdata = {31'h00000000, s_q.merged};
        psfs_pkg::ADDR_STATUS: s_d.rdata = status_word(s_q);
        psfs_pkg::ADDR_DRIVE: s_d.rdata = {30'h00000000, s_q.slew};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (s_q.ap_act && s_q.ap_wr && s_q.ap_addr == psfs_pkg::ADDR_CTRL) begin
      s_d.merged = hwdata[0]; // Software override of combined report
    end
  end

  // Single state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= psfs_pkg::ST_START;
      s_q.aux_en <= 1'b1;
      s_q.neg_en <= 1'b1;
      s_q.cf_n <= 1'b1;
      s_q.cf_oe <= 1'b1;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.rdy;
  assign hresp = s_q.resp;
  assign gate_on = s_q.gate;
  assign slow_turnoff = s_q.slow;
  assign aux_5v_regulator_en = s_q.aux_en;
  assign negative_gate_rail_en = s_q.neg_en;
  assign slew_sel = s_q.slew;
  assign freq_limit = s_q.flim;
  assign temp_force_high = s_q.thot;
  assign general_fault_n = s_q.gf_n;
  assign current_fault_n = s_q.cf_n;
  assign current_fault_oe = s_q.cf_oe;

  // Thermal faults pull general fault low within one cycle
  property p_thermal_fault;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st != psfs_pkg::ST_START && (die_hot || driver_hot)) |=> !general_fault_n;
  endproperty
  a_thermal_fault: assert property (p_thermal_fault) else $error("thermal fault not shown");

  // Undervoltage forces gate off
  property p_supply_undervoltage_lock;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st != psfs_pkg::ST_START && supply_low) |=> (!gate_on && !general_fault_n);
  endproperty
  a_supply_undervoltage_lock: assert property (p_supply_undervoltage_lock) else $error("supply_undervoltage_lock not honoured");

  // Short-circuit shows 0,0
  property p_short_code;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == psfs_pkg::ST_SHORT_OFF) |-> (!general_fault_n && !current_fault_n && !gate_on);
  endproperty
  a_short_code: assert property (p_short_code) else $error("short code wrong");

  // Overcurrent ends once command low
  sequence s_oc_off;
    s_q.st == psfs_pkg::ST_CYCLE_OFF && !switch_cmd && !supply_low && !driver_hot
      && !short_current && !die_hot;
  endsequence
  property p_oc_clear;
    @(posedge ref_clk) disable iff (rst) s_oc_off |=> current_fault_n;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("overcurrent not cleared");

  // Driver hot disables rails
  property p_drv_hot;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st != psfs_pkg::ST_START && !supply_low && driver_hot)
      |=> (!aux_5v_regulator_en && !negative_gate_rail_en && !gate_on);
  endproperty
  a_drv_hot: assert property (p_drv_hot) else $error("driver hot not handled");

  // Diode emulation follows reverse current
  property p_diode_emu;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == psfs_pkg::ST_DIODE_EMU) |-> (gate_on == $past(reverse_current));
  endproperty
  a_diode_emu: assert property (p_diode_emu) else $error("emulation gate wrong");

  // Start-up holds general fault low
  property p_startup;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == psfs_pkg::ST_START) |-> !general_fault_n;
  endproperty
  a_startup: assert property (p_startup) else $error("startup fault released");

  // Short outranks overcurrent in the same cycle
  property p_priority;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == psfs_pkg::ST_RUN && short_current && over_current && !supply_low && !driver_hot)
      |=> (s_q.st == psfs_pkg::ST_SHORT_OFF);
  endproperty
  a_priority: assert property (p_priority) else $error("short lost to overcurrent");

  // Latch holds while command high
  property p_latch_hold;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == psfs_pkg::ST_SHORT_OFF && switch_cmd && !supply_low && !driver_hot)
      |=> (s_q.st == psfs_pkg::ST_SHORT_OFF);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

  // Overcurrent in a running cycle cuts the gate and pulls the current pin
  property p_cycle_enter;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == psfs_pkg::ST_RUN && over_current && switch_cmd && !short_current && !die_hot
      && !supply_low && !driver_hot) |=> (!gate_on && !current_fault_n);
  endproperty
  a_cycle_enter: assert property (p_cycle_enter) else $error("overcurrent cut missing");

  // A fresh short starts the slowed turn-off at once
  property p_slow_start;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == psfs_pkg::ST_RUN && short_current && !supply_low && !driver_hot)
      |=> (slow_turnoff && !gate_on);
  endproperty
  a_slow_start: assert property (p_slow_start) else $error("slow turn-off missing");

  // The slowed drive is a bounded pulse, not a standing state
  localparam int SLOW_SPAN = psfs_pkg::SLOW_OFF_CYC;
  property p_slow_end;
    @(posedge ref_clk) disable iff (rst) $rose(slow_turnoff) |-> ##[1:SLOW_SPAN] !slow_turnoff;
  endproperty
  a_slow_end: assert property (p_slow_end) else $error("slow turn-off stuck");

  // Driver cool with die still hot goes back to emulation with rails on
  property p_emu_return;
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == psfs_pkg::ST_DRV_HOT && !s_q.sc_held && !supply_low && !driver_hot
      && !short_current && die_hot)
      |=> (s_q.st == psfs_pkg::ST_DIODE_EMU && aux_5v_regulator_en);
  endproperty
  a_emu_return: assert property (p_emu_return) else $error("emulation not resumed");

  // Nothing wrong in a running cycle leaves both pins high
  sequence s_all_clear;
    s_q.st == psfs_pkg::ST_RUN && !supply_low && !driver_hot && !short_current && !die_hot
      && !drv_pin_open && !(over_current && switch_cmd);
  endsequence
  property p_normal_high;
    @(posedge ref_clk) disable iff (rst) s_all_clear |=> (general_fault_n && current_fault_n);
  endproperty
  a_normal_high: assert property (p_normal_high) else $error("normal pins not high");

  // A rail-tied drive pin freezes the slew choice
  property p_rail_freeze;
    @(posedge ref_clk) disable iff (rst) s_q.rail_locked |=> $stable(slew_sel);
  endproperty
  a_rail_freeze: assert property (p_rail_freeze) else $error("locked slew changed");

  // Low bias flags the reduced frequency ceiling
  property p_freq_limit;
    @(posedge ref_clk) disable iff (rst) bias_below_9v |=> freq_limit;
  endproperty
  a_freq_limit: assert property (p_freq_limit) else $error("frequency limit missing");
endmodule : psfs_top

// ==== psfs_ctrl_model.sv ====
// Purpose: Behavioural power supply controller facing the fault supervisor
// Assumes: Fault pins are registered levels on ref_clk
// Notes: Decodes the fault pair and drops the command on a short
`timescale 1ns/100ps
module psfs_ctrl_model (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Async reset, active high
  input wire logic pwm_req, // Wanted switch level
  input wire logic merged, // Single-pin reporting strapped
  input wire logic general_fault_n, // General fault pin
  input wire logic current_fault_n, // Current fault pin
  output logic switch_cmd, // Switch command
  output logic [1:0] fault_code // Decoded pair, 0 short 1 other 2 oc 3 ok
);
  logic short_seen;
  // Merged reporting leaves the current pin unused
  assign short_seen = !general_fault_n && !current_fault_n && !merged;
  // Command held low for as long as a short is reported, so the latch can clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switch_cmd <= 1'b0;
      fault_code <= 2'h3;
    end else begin
      fault_code <= {general_fault_n, current_fault_n};
      switch_cmd <= pwm_req && !short_seen;
    end
  end
endmodule : psfs_ctrl_model

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the power switch fault supervisor
// Assumes: Latch reset hold shortened to 20 cycles
// Notes: Second reset covers the rail-tied drive pin and grounded strap
`timescale 1ns/100ps
module tb_top;
  localparam int SC = 20;
  logic ref_clk = 1'b0, rst = 1'b1, pwm_req = 1'b0, merged = 1'b0, switch_cmd;
  logic over_current = 1'b0, short_current = 1'b0, reverse_current = 1'b0;
  logic die_hot = 1'b0, driver_hot = 1'b0, supply_low = 1'b0, bias_below_9v = 1'b0;
  logic series_fet_on = 1'b0, drv_pin_open = 1'b0, drv_pin_gnd = 1'b0;
  logic drv_pin_rail = 1'b0, current_fault_in = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, slew_sel, fault_code;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, gate_on, slow_turnoff, aux_en, neg_en, freq_limit;
  logic temp_force_high, general_fault_n, current_fault_n, current_fault_oe;
  int bad_count = 0, checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  psfs_top #(.SC_RESET_CYCLES(SC)) psfs_top_i (.ref_clk(ref_clk), .rst(rst),
    .switch_cmd(switch_cmd), .over_current(over_current), .short_current(short_current),
    .reverse_current(reverse_current), .die_hot(die_hot), .driver_hot(driver_hot),
    .supply_low(supply_low), .bias_below_9v(bias_below_9v), .series_fet_on(series_fet_on),
    .drv_pin_open(drv_pin_open), .drv_pin_gnd(drv_pin_gnd), .drv_pin_rail(drv_pin_rail),
    .current_fault_in(current_fault_in), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gate_on(gate_on), .slow_turnoff(slow_turnoff),
    .aux_5v_regulator_en(aux_en), .negative_gate_rail_en(neg_en), .slew_sel(slew_sel),
    .freq_limit(freq_limit), .temp_force_high(temp_force_high),
    .general_fault_n(general_fault_n), .current_fault_n(current_fault_n),
    .current_fault_oe(current_fault_oe));
  psfs_ctrl_model psfs_ctrl_model_i (.ref_clk(ref_clk), .rst(rst), .pwm_req(pwm_req),
    .merged(merged), .general_fault_n(general_fault_n), .current_fault_n(current_fault_n),
    .switch_cmd(switch_cmd), .fault_code(fault_code));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // One single AHB-Lite transfer; waits on hready, takes read data at the data edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= psfs_pkg::HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask : bus
  task automatic pair(input logic [31:0] e);
    chk("fault pair", {general_fault_n, current_fault_n}, e);
  endtask : pair
  task automatic t_start;
    tick(5);
    chk("gf start", general_fault_n, 32'h0);
    series_fet_on <= 1'b1;
    tick(4);
    pair(32'h3);
    chk("cf oe", current_fault_oe, 32'h1);
    bus(1'b0, 32'h0 + psfs_pkg::ADDR_STATUS, 32'h0);
    chk("status", r, 32'h61);
    bus(1'b0, 32'h0C, 32'h0);
    chk("unmapped", r, 32'h0);
  endtask : t_start
  // Overcurrent cuts the rest of the cycle only
  task automatic t_ocp;
    pwm_req <= 1'b1;
    tick(5);
    chk("gate run", gate_on, 32'h1);
    over_current <= 1'b1;
    tick(3);
    pair(32'h2);
    over_current <= 1'b0;
    tick(3);
    chk("gate oc", gate_on, 32'h0);
    pwm_req <= 1'b0;
    tick(4);
    pwm_req <= 1'b1;
    tick(5);
    chk("gate next", gate_on, 32'h1);
    pair(32'h3);
  endtask : t_ocp
  // Short with overcurrent at once: latch, slow off, needs long low command
  task automatic t_short;
    short_current <= 1'b1;
    over_current <= 1'b1;
    tick(2);
    chk("slow off", slow_turnoff, 32'h1);
    tick(1);
    chk("gate sc", gate_on, 32'h0);
    pair(32'h0);
    short_current <= 1'b0;
    over_current <= 1'b0;
    tick(10);
    pair(32'h0);
    chk("slow end", slow_turnoff, 32'h0);
    chk("ctrl code", fault_code, 32'h0);
    tick(2 * SC + 10);
    pair(32'h3);
    chk("gate back", gate_on, 32'h1);
    chk("ctrl code ok", fault_code, 32'h3);
    pwm_req <= 1'b0;
  endtask : t_short
  // Die hot, then driver hot on top, then cool down in steps
  task automatic t_therm;
    die_hot <= 1'b1;
    tick(3);
    pair(32'h1);
    chk("temp high", temp_force_high, 32'h1);
    chk("emu off", gate_on, 32'h0);
    reverse_current <= 1'b1;
    tick(3);
    chk("emu on", gate_on, 32'h1);
    driver_hot <= 1'b1;
    tick(3);
    chk("drv hot", {gate_on, aux_en, neg_en}, 32'h0);
    pair(32'h1);
    driver_hot <= 1'b0;
    tick(3);
    chk("emu again", {gate_on, aux_en, neg_en}, 32'h7);
    die_hot <= 1'b0;
    reverse_current <= 1'b0;
    tick(3);
    pair(32'h3);
    chk("temp low", temp_force_high, 32'h0);
  endtask : t_therm
  task automatic t_misc;
    pwm_req <= 1'b1;
    supply_low <= 1'b1;
    bias_below_9v <= 1'b1;
    tick(4);
    chk("supply_undervoltage_lock gate", gate_on, 32'h0);
    pair(32'h1);
    chk("freq", freq_limit, 32'h1);
    supply_low <= 1'b0;
    bias_below_9v <= 1'b0;
    drv_pin_open <= 1'b1;
    tick(4);
    pair(32'h1);
    drv_pin_open <= 1'b0;
    bus(1'b1, 32'h0 + psfs_pkg::ADDR_CTRL, 32'h1);
    merged <= 1'b1;
    over_current <= 1'b1;
    tick(3);
    pair(32'h0);
    chk("gate merged", gate_on, 32'h0);
    over_current <= 1'b0;
    pwm_req <= 1'b0;
    bus(1'b1, 32'h0 + psfs_pkg::ADDR_CTRL, 32'h0);
    merged <= 1'b0;
  endtask : t_misc
  // A short blip is filtered out, a long one is taken
  task automatic t_slew;
    drv_pin_gnd <= 1'b1;
    tick(500);
    drv_pin_gnd <= 1'b0;
    tick(600);
    chk("slew blip", slew_sel, 32'h0 + psfs_pkg::SLEW_EXT);
    drv_pin_gnd <= 1'b1;
    tick(psfs_pkg::FILT_CYC + 20);
    chk("slew gnd", slew_sel, 32'h0 + psfs_pkg::SLEW_150);
    bus(1'b0, 32'h0 + psfs_pkg::ADDR_DRIVE, 32'h0);
    chk("drive reg", r, 32'h0 + psfs_pkg::SLEW_150);
    drv_pin_gnd <= 1'b0;
  endtask : t_slew
  // Second reset with rail-tied drive pin and grounded current pin
  task automatic t_strap;
    rst <= 1'b1;
    drv_pin_rail <= 1'b1;
    current_fault_in <= 1'b0;
    tick(3);
    rst <= 1'b0;
    tick(5);
    drv_pin_rail <= 1'b0;
    drv_pin_gnd <= 1'b1;
    chk("cf oe strap", current_fault_oe, 32'h0);
    tick(psfs_pkg::FILT_CYC + 20);
    chk("slew rail", slew_sel, 32'h0 + psfs_pkg::SLEW_100);
    bus(1'b0, 32'h0 + psfs_pkg::ADDR_STATUS, 32'h0);
    chk("locks", r[10:9], 32'h3);
  endtask : t_strap
  task automatic results;
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    tick(3);
    rst <= 1'b0;
    t_start();
    t_ocp();
    t_short();
    t_therm();
    t_misc();
    t_slew();
    t_strap();
    results();
  end
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule : tb_top
